// ===== inc/wdit_cfg.svh
`ifndef WDIT_CFG_SVH
`define WDIT_CFG_SVH
`define WDIT_ADDR_CLKSEL 16'hff42
`define WDIT_ADDR_MODE 16'hfff9
`define WDIT_CLKSEL_RST 8'h00
`define WDIT_MODE_RST 8'h00
`define WDIT_CLKSEL_MASK 8'h07
`define WDIT_MODE_MASK 8'h98
`define WDIT_BIT_RUN 7
`define WDIT_BIT_WDMODE 4
`define WDIT_BIT_ACTION 3
`define WDIT_PRESC_W 10
`define WDIT_CNT_W 7
`endif

// ===== inc/wdit_pkg.sv
package wdit_pkg;
  typedef enum logic [1:0] {
    WDIT_STOPPED,
    WDIT_INTERVAL,
    WDIT_WDOG_NMI,
    WDIT_WDOG_RST
  } wdit_mode_e;
endpackage

// ===== inc/wdit_tick_if.sv
`timescale 1ns/1ps
interface wdit_tick_if;
  logic [2:0] sel;
  logic run;
  logic tick;
  modport src (input sel, input run, output tick);
  modport dst (output sel, output run, input tick);
endinterface

// ===== hdl/wdit_prescaler.sv
`timescale 1ns/1ps
`include "wdit_cfg.svh"
module wdit_prescaler (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // tick out
  wdit_tick_if.src tk
);
  typedef struct packed {
    logic [`WDIT_PRESC_W-1:0] div;
    logic tick;
  } wdit_presc_s;
  wdit_presc_s s_q, s_d;

  // tap = 4 + 2*code[2:1]; prescaler never cleared by restart
  function automatic logic tap_edge(input logic [`WDIT_PRESC_W-1:0] d, input logic [2:0] sel);
    logic [`WDIT_PRESC_W-1:0] m;
    m = '0;
    case (sel[2:1])
      2'b00: m = 10'h00f;
      2'b01: m = 10'h03f;
      2'b10: m = 10'h0ff;
      default: m = 10'h3ff;
    endcase
    return (d & m) == m;
  endfunction

  always_comb begin
    s_d = s_q;
    // stop freezes via run gating in top
    if (tk.run) begin
      s_d.div = s_q.div + 10'h001;
    end
    s_d.tick = tk.run && tap_edge(s_q.div, tk.sel);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tk.tick = s_q.tick;
endmodule

// ===== hdl/wdit_counter.sv
`timescale 1ns/1ps
`include "wdit_cfg.svh"
module wdit_counter (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // control
  input wire logic clear_i,
  input wire logic tick_i,
  // overflow pulse
  output logic ovf_o
);
  typedef struct packed {
    logic [`WDIT_CNT_W-1:0] cnt;
    logic ovf;
  } wdit_cnt_s;
  wdit_cnt_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.ovf = 1'b0;
    if (clear_i) begin
      s_d.cnt = '0;
    end else if (tick_i) begin
      s_d.cnt = s_q.cnt + 7'h01;
      s_d.ovf = &s_q.cnt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ovf_o = s_q.ovf;
endmodule

// ===== hdl/wdit_top.sv
`timescale 1ns/1ps
`include "wdit_cfg.svh"
module wdit_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // power state and interrupt controller flags
  input wire logic stop_mode_i,
  input wire logic timer_irq_request_flag_i,
  input wire logic timer_irq_mask_flag_i,
  // events
  output logic interval_overflow_irq_o,
  output logic interval_irq_pending_o,
  output logic nmi_o,
  output logic wdt_reset_o,
  output logic [1:0] mode_o
);
  typedef struct packed {
    logic [2:0] clk_sel;
    logic run;
    logic wd_mode;
    logic action;
    logic restart;
    logic [7:0] rdata;
    logic irq;
    logic pend;
    logic nmi;
    logic rst;
    wdit_pkg::wdit_mode_e mode;
  } wdit_top_s;
  wdit_top_s s_q, s_d;

  wdit_tick_if tk ();
  logic ovf;
  logic stop_s1_q, stop_s2_q;
  logic wr_clk, wr_mode;

  wdit_prescaler u_presc (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .tk(tk.src)
  );

  wdit_counter u_cnt (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .clear_i(s_q.restart),
    .tick_i(tk.tick),
    .ovf_o(ovf)
  );

  // stop request comes from the power controller, treat as asynchronous
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
    end else begin
      stop_s1_q <= stop_mode_i;
      stop_s2_q <= stop_s1_q;
    end
  end

  assign wr_clk = reg_wr_i && (reg_addr_i == `WDIT_ADDR_CLKSEL);
  assign wr_mode = reg_wr_i && (reg_addr_i == `WDIT_ADDR_MODE);
  assign tk.sel = s_q.clk_sel;
  // halt keeps counting, stop freezes both stages
  assign tk.run = s_q.run && !stop_s2_q;

  always_comb begin
    s_d = s_q;
    s_d.restart = 1'b0;
    s_d.irq = 1'b0;
    s_d.nmi = 1'b0;
    s_d.rst = 1'b0;
    if (wr_clk) begin
      s_d.clk_sel = reg_wdata_i[2:0];
    end
    if (wr_mode) begin
      // each write of one restarts the count
      if (reg_wdata_i[`WDIT_BIT_RUN]) begin
        s_d.run = 1'b1;
        s_d.restart = 1'b1;
      end
      s_d.wd_mode = s_q.wd_mode | reg_wdata_i[`WDIT_BIT_WDMODE];
      s_d.action = s_q.action | reg_wdata_i[`WDIT_BIT_ACTION];
      if (!s_q.wd_mode && reg_wdata_i[`WDIT_BIT_WDMODE] && timer_irq_request_flag_i) begin
        s_d.nmi = 1'b1;
      end
    end
    case ({s_q.wd_mode, s_q.action})
      2'b00: s_d.mode = wdit_pkg::WDIT_STOPPED;
      2'b01: s_d.mode = wdit_pkg::WDIT_INTERVAL;
      2'b10: s_d.mode = wdit_pkg::WDIT_WDOG_NMI;
      default: s_d.mode = wdit_pkg::WDIT_WDOG_RST;
    endcase
    if (ovf) begin
      case (s_q.mode)
        wdit_pkg::WDIT_INTERVAL: s_d.irq = 1'b1;
        wdit_pkg::WDIT_WDOG_NMI: s_d.nmi = 1'b1;
        wdit_pkg::WDIT_WDOG_RST: s_d.rst = 1'b1;
        default: s_d.irq = 1'b0;
      endcase
    end
    // mask gates; priority resolved by controller on this line
    s_d.pend = (s_q.mode == wdit_pkg::WDIT_INTERVAL) && timer_irq_request_flag_i && !timer_irq_mask_flag_i;
    case (reg_addr_i)
      `WDIT_ADDR_CLKSEL: s_d.rdata = {5'h00, s_q.clk_sel} & `WDIT_CLKSEL_MASK;
      `WDIT_ADDR_MODE: s_d.rdata = {s_q.run, 2'h0, s_q.wd_mode, s_q.action, 3'h0} & `WDIT_MODE_MASK;
      default: s_d.rdata = 8'h00;
    endcase
  end

  // registers reset to zero; run cleared only here
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // irq pulse sets the request flag in the controller
  assign interval_overflow_irq_o = s_q.irq;
  assign interval_irq_pending_o = s_q.pend;
  assign nmi_o = s_q.nmi;
  assign wdt_reset_o = s_q.rst;
  assign reg_rdata_o = s_q.rdata;
  assign mode_o = s_q.mode;
endmodule

// ===== bench/wdit_irq_ctrl.sv
`timescale 1ns/1ps
module wdit_irq_ctrl (
  // clock, reset, overflow in, flag out
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic set_i,
  output logic flag_o
);
  // flag set by overflow
  // software clear is not modelled, so the flag stays up until reset
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end
  end
endmodule

// ===== bench/wdit_top_assertions.sv
`timescale 1ns/1ps
module wdit_top_assertions (
  // watched ports
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic stop_mode_i,
  input wire logic timer_irq_mask_flag_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic interval_overflow_irq_o,
  input wire logic interval_irq_pending_o,
  input wire logic nmi_o,
  input wire logic wdt_reset_o,
  input wire logic [1:0] mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_sel_zero: assert property ($past(reg_addr_i) == 16'hff42 |-> reg_rdata_o[7:3] == 5'h00) else $error("sel");
  a_mode_zero: assert property ($past(reg_addr_i) == 16'hfff9 |-> (reg_rdata_o & 8'h67) == 8'h00) else $error("mode");
  a_mode_sticky: assert property (1'b1 |=> (mode_o | $past(mode_o)) == mode_o) else $error("sticky");
  a_irq_interval: assert property (interval_overflow_irq_o |-> mode_o == 2'h1) else $error("irq");
  a_reset_mode: assert property (wdt_reset_o |-> mode_o == 2'h3) else $error("rst");
  a_stopped_quiet: assert property (mode_o == 2'h0 |-> !(interval_overflow_irq_o || wdt_reset_o)) else $error("off");
  a_mask_gates: assert property ($past(timer_irq_mask_flag_i) |-> !interval_irq_pending_o) else $error("mask");
  a_stop_freeze: assert property (stop_mode_i [*6] |-> !(interval_overflow_irq_o || wdt_reset_o)) else $error("stop");
  cover property (nmi_o);
  cover property (wdt_reset_o);
  cover property (interval_irq_pending_o);
endmodule
bind wdit_top wdit_top_assertions u_chk (.*);

// ===== bench/wdit_tb_top.sv
`timescale 1ns/1ps
module wdit_tb_top;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, wr = 1'b0, stop = 1'b0, mask = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00, rdata;
  logic irq, pend, nmi, rst_o, flag;
  logic [1:0] mode;
  logic [31:0] n;
  int failures = 0, compares = 0;
  wire [2:0] ev = {rst_o, nmi, irq};
  always #5 mclk_i = ~mclk_i;
  wdit_top u_dut (.mclk_i, .rst_b_i, .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
    .stop_mode_i(stop), .timer_irq_request_flag_i(flag), .timer_irq_mask_flag_i(mask),
    .interval_overflow_irq_o(irq), .interval_irq_pending_o(pend), .nmi_o(nmi), .wdt_reset_o(rst_o), .mode_o(mode));
  wdit_irq_ctrl u_ic (.mclk_i, .rst_b_i, .set_i(irq), .flag_o(flag));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t got %0h want %0h", $time, s, e);
    end
  endtask
  task automatic w(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr <= a;
    @(posedge mclk_i);
    #1 chk(rdata, e);
  endtask
  // n counts cycles until event k (0 irq, 1 nmi, 2 reset) or the limit
  task automatic wev(input int k, lim, lo, hi);
    n = 0;
    do begin
      @(posedge mclk_i);
      #1 n++;
    end while (ev[k] !== 1'b1 && n < lim);
    chk(n >= lo && n <= hi, 1'b1);
  endtask
  task automatic t_int();
    rc(16'hff42, 8'h00);
    rc(16'hfff9, 8'h00);
    w(16'hff42, 8'hff);
    rc(16'hff42, 8'h07);
    w(16'hff42, 8'h00);
    w(16'hfff9, 8'h88);
    wev(0, 3000, 2029, 2051);
    wev(0, 3000, 2048, 2048);
    repeat (3) @(posedge mclk_i);
    mask <= 1'b1;
    #1 chk(pend, 1'b1);
    w(16'hfff9, 8'h00);
    rc(16'hfff9, 8'h88);
    chk(mode, 2'h1);
    w(16'hff42, 8'h02);
    wev(0, 9000, 1, 9000);
    wev(0, 9000, 8192, 8192);
    w(16'hfff9, 8'h88);
    stop <= 1'b1;
    wev(0, 9000, 9000, 9000);
    @(posedge mclk_i);
    stop <= 1'b0;
    $display("t_int end");
  endtask
  task automatic t_wdog();
    w(16'hff42, 8'h00);
    // flag left set on purpose so that the entry interrupt shows
    chk(flag, 1'b1);
    fork
      w(16'hfff9, 8'h98);
      wev(1, 8, 2, 3);
    join
    rc(16'hfff9, 8'h98);
    chk(mode, 2'h3);
    repeat (1500) @(posedge mclk_i);
    w(16'hfff9, 8'h98);
    wev(2, 3000, 2020, 2055);
    $display("t_wdog end");
  endtask
  task automatic tally_and_finish();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_int();
    t_wdog();
    tally_and_finish();
  end
  initial begin
    #1000000;
    failures++;
    tally_and_finish();
  end
endmodule
